// File: rtl/power_manager_map.vh
// Constants for the power manager reset and clock block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
// Behaviour
// [RL1] Software disables generic clock before changing it
// [RL2] Five generic clocks: three pins, USB, DAC
// [RL3] Divided bus clocks stop with undivided ones
// [RL4] Qualified clocks stop in debug unless kept
// [RL5] Divided clocks always debug qualified
// [RL6] Power-on holds reset while supply low
// [RL7] Low external reset pin causes reset
// [RL8] Six reset sources collected; the code collects seven, each with its own cause bit
// [RL9] Power-on alone resets low-power domain
// [RL10] All sources reset bus and clock logic
// [RL11] Debug survives watchdog/debug; watchdog survives watchdog
// [RL12] RC calibration power-on only; brownout/bandgap also external
// [RL13] Reset cause readable, one bit each
// [RL14] Test port holds parts in reset
// [RL15] Brownout threshold programmable, off by default
// [RL16] Brownout raises interrupt or reset
// [RL17] Brownout detection bit always readable
// [RL18] Change threshold only with brownout disabled
// [RL19] Calibration loaded from fuses after power-on
// [RL20] Calibration write needs 0x55 then 0xAA
// [RL21] Overriding factory calibration discouraged
// [RL22] Disabled generic clock stops at falling edge
// [RL23] Source select; divide by 2*(DIV+1)
// [RL24] Bad unlock sequence leaves register, relocks
// [RL25] Cause register holds only latest source
`ifndef POWER_MANAGER_MAP_VH
`define POWER_MANAGER_MAP_VH
`define PM_ADDR_W 10
`define PM_GCC0 10'h060
`define PM_RCCR 10'h0C0
`define PM_BGCR 10'h0C4
`define PM_VREGCR 10'h0C8
`define PM_BOD 10'h0D0
`define PM_RESET_CAUSE_REGISTER 10'h140
`define PM_POSCSR 10'h054
`define PM_GPLP0 10'h200
`define PM_GPLP1 10'h204
`define PM_DBGCTL 10'h180
`define PM_NUM_GCLK 5
`define GC_CEN 2
`define GC_DIVEN 4
`define GC_OSCSEL 0
`define GC_PLLSEL 1
`define GC_DIV_LSB 8
`define GC_DIV_MSB 15
`define BOD_LVL_MSB 5
`define BOD_HYST 6
`define BOD_CTRL_LSB 8
`define BOD_CTRL_MSB 9
`define BOD_ACT_RESET 2'h1
`define BOD_ACT_IRQ 2'h2
`define KEY_LSB 24
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define CAUSE_POR 0
`define CAUSE_BOD 1
`define CAUSE_EXT 2
`define CAUSE_WDT 3
`define CAUSE_JTAG 4
`define CAUSE_CPUERR 7
`define CAUSE_OCD 8
`define POSCSR_BODET 16
`define RST_DIGITAL 32'h00000000
`endif

// File: rtl/power_manager_reset_clock_ctl.v
// Reset controller, brownout, calibration and generic clocks.
// Assumes analog comparators and clock sources arrive synchronous to clk_i.
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "power_manager_map.vh"
module power_manager_reset_clock_ctl (
	input wire clk_i,
	input wire nrst_i,
	input wire [9:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire por_below_i,
	input wire ext_reset_n_i,
	input wire bod_below_i,
	input wire cpu_error_i,
	input wire wdt_reset_i,
	input wire ocd_reset_i,
	input wire jtag_hold_i,
	input wire [3:0] gc_src_i,
	input wire pb_run_a_i,
	input wire pb_run_b_i,
	input wire pba_div_tick_i,
	input wire pbb_div_tick_i,
	input wire debug_halt_i,
	input wire debug_keep_i,
	input wire fuse_valid_i,
	input wire [31:0] fuse_rc_i,
	input wire [31:0] fuse_bg_i,
	input wire [31:0] fuse_vreg_i,
	input wire [9:0] fuse_bod_i,
	output wire [`PM_NUM_GCLK-1:0] generic_clock_o,
	output wire pba_div_en_o,
	output wire pbb_div_en_o,
	output wire pba_dbg_en_o,
	output wire pbb_dbg_en_o,
	output reg sys_reset_o,
	output reg wdt_ctrl_reset_o,
	output reg ocd_reset_o,
	output reg por_domain_reset_o,
	output reg brownout_irq_o
);
	reg [31:0] gcc_q [0:`PM_NUM_GCLK-1];
	reg [7:0] gcnt_q [0:`PM_NUM_GCLK-1];
	reg [`PM_NUM_GCLK-1:0] gout_q;
	reg [`PM_NUM_GCLK-1:0] gsrc_q;
	reg [31:0] rccr_q, bgcr_q, vregcr_q, gplp0_q, gplp1_q;
	reg [9:0] bod_q;
	reg [8:0] cause_q;
	reg [1:0] key_q;
	reg [31:0] rdata_q;
	reg dbgkeep_q;
	reg rd_wait_q;
	reg fuse_done_q;
	wire ext_low = ~ext_reset_n_i; // see [RL7]
	wire bod_act = bod_below_i & (bod_q[`BOD_CTRL_MSB:`BOD_CTRL_LSB] == `BOD_ACT_RESET); // see [RL16]
	wire any_soft = ext_low | bod_act | cpu_error_i | wdt_reset_i | ocd_reset_i; // see [RL8]
	wire wr = avs_write_i;
	wire [7:0] key_in = avs_writedata_i[31:24];
	integer i;

	function is_cal;
		input [9:0] a;
		begin
			is_cal = (a == `PM_RCCR) || (a == `PM_BGCR) || (a == `PM_VREGCR) || (a == `PM_BOD);
		end
	endfunction

	function [2:0] gc_idx;
		input [9:0] a;
		begin
			gc_idx = a[4:2];
		end
	endfunction

	// One wait state on reads so registered data stands at the accepting edge
	assign avs_waitrequest_o = avs_read_i & ~rd_wait_q;
	assign avs_readdata_o = rdata_q;

	always @(posedge clk_i) begin
		if (!nrst_i)
			rd_wait_q <= 1'b0;
		else
			rd_wait_q <= avs_read_i & ~rd_wait_q;
	end
	// Reset outputs, decoded per source
	always @(posedge clk_i) begin
		sys_reset_o <= ~nrst_i | por_below_i | any_soft | jtag_hold_i; // see [RL6] see [RL10] see [RL14]
		ocd_reset_o <= ~nrst_i | por_below_i | ext_low | bod_act | cpu_error_i; // see [RL11]
		wdt_ctrl_reset_o <= ~nrst_i | por_below_i | ext_low | bod_act | cpu_error_i | ocd_reset_i; // see [RL11]
		por_domain_reset_o <= ~nrst_i | por_below_i; // see [RL9]
		brownout_irq_o <= bod_below_i & (bod_q[`BOD_CTRL_MSB:`BOD_CTRL_LSB] == `BOD_ACT_IRQ); // see [RL16]
	end

	// Reset cause: latest source only
	always @(posedge clk_i) begin
		if (!nrst_i || por_below_i)
			cause_q <= 9'h001; // see [RL25]
		else if (ext_low)
			cause_q <= 9'h004; // see [RL13]
		else if (bod_act)
			cause_q <= 9'h002;
		else if (wdt_reset_i)
			cause_q <= 9'h008;
		else if (jtag_hold_i)
			cause_q <= 9'h010;
		else if (cpu_error_i)
			cause_q <= 9'h080;
		else if (ocd_reset_i)
			cause_q <= 9'h100;
	end

	// Calibration and low-power registers; power-on domain
	always @(posedge clk_i) begin
		if (!nrst_i || por_below_i) begin
			rccr_q <= `RST_DIGITAL;
			vregcr_q <= `RST_DIGITAL;
			gplp0_q <= `RST_DIGITAL;
			gplp1_q <= `RST_DIGITAL;
			fuse_done_q <= 1'b0;
		end else if (!fuse_done_q) begin
			if (fuse_valid_i) begin
				rccr_q <= fuse_rc_i; // see [RL19] see [RL12]
				vregcr_q <= fuse_vreg_i;
				fuse_done_q <= 1'b1;
			end
		end else if (wr && key_q == 2'h1 && key_in == `KEY_SECOND) begin
			if (avs_address_i == `PM_RCCR)
				rccr_q <= avs_writedata_i; // see [RL20]
			if (avs_address_i == `PM_VREGCR)
				vregcr_q <= avs_writedata_i;
		end else if (wr && avs_address_i == `PM_GPLP0) begin
			gplp0_q <= avs_writedata_i;
		end else if (wr && avs_address_i == `PM_GPLP1) begin
			gplp1_q <= avs_writedata_i;
		end
	end

	// Brownout and bandgap: power-on and external reset; fuses reload after either
	always @(posedge clk_i) begin
		if (!nrst_i || por_below_i || ext_low) begin
			bgcr_q <= `RST_DIGITAL;
			bod_q <= 10'h000; // see [RL15]
		end else if (!fuse_done_q || (fuse_valid_i && bod_q == 10'h000 && bgcr_q == `RST_DIGITAL && key_q == 2'h0 && !wr)) begin
			if (fuse_valid_i) begin
				bgcr_q <= fuse_bg_i; // see [RL19]
				bod_q <= fuse_bod_i; // see [RL15]
			end
		end else if (wr && key_q == 2'h1 && key_in == `KEY_SECOND) begin
			if (avs_address_i == `PM_BGCR)
				bgcr_q <= avs_writedata_i;
			if (avs_address_i == `PM_BOD)
				bod_q <= avs_writedata_i[9:0]; // see [RL20]
		end
	end

	// Unlock: 0x55 arms, matching 0xAA commits, anything else relocks
	always @(posedge clk_i) begin
		if (!nrst_i || por_below_i)
			key_q <= 2'h0;
		else if (wr && is_cal(avs_address_i)) begin
			if (key_q == 2'h0 && key_in == `KEY_FIRST)
				key_q <= 2'h1; // see [RL20]
			else
				key_q <= 2'h0; // see [RL24]
		end else if (wr)
			key_q <= 2'h0; // see [RL24]
	end

	// Debug keep-running flag
	always @(posedge clk_i) begin
		if (!nrst_i || sys_reset_o)
			dbgkeep_q <= 1'b0;
		else if (wr && avs_address_i == `PM_DBGCTL)
			dbgkeep_q <= avs_writedata_i[0];
	end

	wire dbg_run = ~debug_halt_i | debug_keep_i | dbgkeep_q; // see [RL4]
	assign pba_dbg_en_o = pb_run_a_i & dbg_run;
	wire pbb_dbg_en_w = pb_run_b_i & dbg_run;
	assign pbb_dbg_en_o = pbb_dbg_en_w;
	assign pba_div_en_o = pba_div_tick_i & pb_run_a_i & dbg_run; // see [RL3] see [RL5]
	assign pbb_div_en_o = pbb_div_tick_i & pb_run_b_i & dbg_run; // see [RL3] see [RL5]

	// Generic clocks; source samples are synchronous levels
	always @(posedge clk_i) begin
		for (i = 0; i < `PM_NUM_GCLK; i = i + 1) begin
			if (!nrst_i || sys_reset_o) begin
				gcc_q[i] <= `RST_DIGITAL; // see [RL10]
				gcnt_q[i] <= 8'h00;
				gout_q[i] <= 1'b0;
				gsrc_q[i] <= 1'b0;
			end else begin
				gsrc_q[i] <= gc_src_i[{gcc_q[i][`GC_PLLSEL], gcc_q[i][`GC_OSCSEL]}]; // see [RL23]
				if (wr && avs_address_i[9:5] == 5'h03 && gc_idx(avs_address_i) == i[2:0]) begin
					if (avs_writedata_i[`GC_CEN] || !gcc_q[i][`GC_CEN])
						gcc_q[i] <= avs_writedata_i;
					else
						gcc_q[i] <= {gcc_q[i][31:3], 1'b1, gcc_q[i][1:0]} & 32'h0000FF17 | 32'h00000004;
				end
				// Falling source edge ends a pending disable, so no runt pulse
				if (gsrc_q[i] && !gc_src_i[{gcc_q[i][`GC_PLLSEL], gcc_q[i][`GC_OSCSEL]}]) begin
					if (!pb_run_a_i || (gcc_q[i][`GC_CEN] && gcc_q[i][3])) begin
						gcc_q[i][`GC_CEN] <= pb_run_a_i ? 1'b0 : gcc_q[i][`GC_CEN]; // see [RL22]
						gcc_q[i][3] <= 1'b0;
						gout_q[i] <= 1'b0;
						gcnt_q[i] <= 8'h00;
					end else if (gcc_q[i][`GC_CEN]) begin
						if (!gcc_q[i][`GC_DIVEN])
							gout_q[i] <= 1'b1;
						else if (gcnt_q[i] == gcc_q[i][`GC_DIV_MSB:`GC_DIV_LSB]) begin
							gcnt_q[i] <= 8'h00;
							gout_q[i] <= ~gout_q[i]; // see [RL23]
						end else
							gcnt_q[i] <= gcnt_q[i] + 8'h01;
					end
				end else if (!gcc_q[i][`GC_DIVEN] && gsrc_q[i] == 1'b0 && gc_src_i[{gcc_q[i][`GC_PLLSEL],
						gcc_q[i][`GC_OSCSEL]}] && gcc_q[i][`GC_CEN] && pb_run_a_i)
					gout_q[i] <= 1'b1;
				if (wr && avs_address_i[9:5] == 5'h03 && gc_idx(avs_address_i) == i[2:0] &&
						!avs_writedata_i[`GC_CEN] && gcc_q[i][`GC_CEN])
					gcc_q[i][3] <= 1'b1;
			end
		end
	end

	assign generic_clock_o = gout_q; // see [RL2]

	// Read mux
	always @(posedge clk_i) begin
		if (!nrst_i)
			rdata_q <= 32'h00000000;
		else if (avs_read_i && !rd_wait_q) begin
			case (avs_address_i)
			`PM_RCCR: rdata_q <= rccr_q;
			`PM_BGCR: rdata_q <= bgcr_q;
			`PM_VREGCR: rdata_q <= vregcr_q;
			`PM_BOD: rdata_q <= {22'h000000, bod_q};
			`PM_RESET_CAUSE_REGISTER: rdata_q <= {23'h000000, cause_q}; // see [RL13]
			`PM_POSCSR: rdata_q <= {15'h0000, bod_below_i, 16'h0000}; // see [RL17]
			`PM_GPLP0: rdata_q <= gplp0_q;
			`PM_GPLP1: rdata_q <= gplp1_q;
			`PM_DBGCTL: rdata_q <= {31'h00000000, dbgkeep_q};
			default: begin
				if (avs_address_i[9:5] == 5'h03 && avs_address_i[4:2] < 3'h5)
					rdata_q <= gcc_q[avs_address_i[4:2]] & 32'hFFFFFFF7;
				else
					rdata_q <= 32'h00000000;
			end
			endcase
		end
	end
endmodule // power_manager_reset_clock_ctl

// File: tb/pm_clock_partner.sv
// Clock sources and reset pin at the far side of the block.
// Assumes the sources run synchronous to clk_i.
`timescale 1ns/1ps
module pm_clock_partner (
	input wire clk_i,
	input wire pin_low_i,
	input wire [4:0] gclk_i,
	input wire [2:0] sel_i,
	output wire ext_reset_n_o,
	output wire [3:0] src_o,
	output reg [7:0] period_o
);
	reg [3:0] cnt_q = 4'h0;
	reg prev_q = 1'b0;
	reg [7:0] age_q = 8'h00;
	// Pulled up, so high unless pulled low
	assign ext_reset_n_o = !pin_low_i;
	// Source n has a period of 2^(n+1) cycles
	assign src_o = cnt_q;
	always @(posedge clk_i) begin
		cnt_q <= cnt_q + 4'h1;
		prev_q <= gclk_i[sel_i];
		age_q <= (gclk_i[sel_i] && !prev_q) ? 8'h01 : age_q + 8'h01;
		if (gclk_i[sel_i] && !prev_q) begin
			period_o <= age_q;
		end
	end
endmodule // pm_clock_partner

// File: tb/power_manager_properties.sv
// Checker for the power manager reset and clock block.
// Assumes it is bound to the top module.
`timescale 1ns/1ps
`include "power_manager_map.vh"
module power_manager_checker (
	input wire clk_i,
	input wire nrst_i,
	input wire [9:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [31:0] avs_readdata_o,
	input wire por_below_i,
	input wire ext_reset_n_i,
	input wire bod_below_i,
	input wire cpu_error_i,
	input wire wdt_reset_i,
	input wire jtag_hold_i,
	input wire pb_run_a_i,
	input wire debug_halt_i,
	input wire debug_keep_i,
	input wire [`PM_NUM_GCLK-1:0] generic_clock_o,
	input wire pba_div_en_o,
	input wire pba_dbg_en_o,
	input wire pbb_dbg_en_o,
	input wire sys_reset_o,
	input wire wdt_ctrl_reset_o,
	input wire ocd_reset_o,
	input wire por_domain_reset_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire others = por_below_i | !ext_reset_n_i | bod_below_i | cpu_error_i | jtag_hold_i;
	sequence s_gc_off;
		avs_write_i && avs_address_i == `PM_GCC0 && !avs_writedata_i[`GC_CEN];
	endsequence
	sequence s_gc_quiet;
		!generic_clock_o[0] [*4];
	endsequence
	a_por_holds_all: assert property (por_below_i |=> sys_reset_o && por_domain_reset_o) else $error("por");
	a_pin_low_resets: assert property (!ext_reset_n_i |=> sys_reset_o) else $error("pin");
	a_cpu_err_full: assert property (cpu_error_i |=> sys_reset_o && ocd_reset_o && wdt_ctrl_reset_o) else $error("cpu");
	a_wdt_spares_debug: assert property (wdt_reset_i && !others |=> !ocd_reset_o && !por_domain_reset_o) else $error("wdt");
	a_ext_spares_lp: assert property (!ext_reset_n_i && !por_below_i |=> !por_domain_reset_o) else $error("ext");
	a_bod_bit_read: assert property (bod_below_i && $past(bod_below_i) && avs_read_i && avs_address_i == `PM_POSCSR
		|=> avs_readdata_o[`POSCSR_BODET]) else $error("bod bit");
	a_debug_stops_qual: assert property (debug_halt_i && !debug_keep_i |-> !pba_div_en_o && !pba_dbg_en_o && !pbb_dbg_en_o)
		else $error("debug");
	a_sleep_stops_div: assert property (!pb_run_a_i |-> !pba_div_en_o) else $error("sleep");
	a_gclk_stops: assert property (s_gc_off |=> ##[0:40] s_gc_quiet) else $error("gclk");
	a_jtag_holds: assert property (jtag_hold_i |=> sys_reset_o) else $error("jtag");
endmodule // power_manager_checker
bind power_manager_reset_clock_ctl power_manager_checker u_chk (.*);

// File: tb/test_power_manager_reset_clock_ctl.sv
// Self-checking bench for the power manager reset and clock block.
// Assumes read data stand at the edge where waitrequest is seen low.
`timescale 1ns/1ps
`include "power_manager_map.vh"
module test_power_manager_reset_clock_ctl;
	typedef struct packed {logic [4:0] src; logic [3:0] outs; logic [3:0] cause;} row_t;
	row_t rows [5] = '{'{5'h02, 4'hE, 4'h2}, '{5'h04, 4'h8, 4'h3}, '{5'h08, 4'hE, 4'h7}, '{5'h10, 4'hC, 4'h8},
		'{5'h01, 4'hF, 4'h0}};
	reg clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, pin_low = 1'b0, fuse_valid_i = 1'b0;
	reg por_below_i = 1'b0, bod_below_i = 1'b0, cpu_error_i = 1'b0, wdt_reset_i = 1'b0, ocd_reset_i = 1'b0;
	reg jtag_hold_i = 1'b0, pb_run_a_i = 1'b1, pb_run_b_i = 1'b1, pba_div_tick_i = 1'b1, pbb_div_tick_i = 1'b1;
	reg debug_halt_i = 1'b0, debug_keep_i = 1'b0;
	reg [9:0] avs_address_i = 10'h000;
	reg [31:0] avs_writedata_i = 32'h00000000, d, w;
	reg [3:0] avs_byteenable_i = 4'hF;
	reg [2:0] sel = 3'h0;
	wire ext_reset_n_i, avs_waitrequest_o, pba_div_en_o, pbb_div_en_o, pba_dbg_en_o, pbb_dbg_en_o, brownout_irq_o;
	wire sys_reset_o, wdt_ctrl_reset_o, ocd_reset_o, por_domain_reset_o;
	wire [3:0] gc_src_i;
	wire [31:0] avs_readdata_o, fuse_rc_i = 32'h00123456, fuse_bg_i = 32'h00234567, fuse_vreg_i = 32'h00345678;
	wire [9:0] fuse_bod_i = 10'h000;
	wire [4:0] generic_clock_o;
	wire [7:0] period;
	wire [3:0] pb_en = {pba_div_en_o, pbb_div_en_o, pba_dbg_en_o, pbb_dbg_en_o};
	integer fails = 0, check_count = 0, i;
	power_manager_reset_clock_ctl u_dut (.*);
	pm_clock_partner u_far (.clk_i(clk_i), .pin_low_i(pin_low), .gclk_i(generic_clock_o), .sel_i(sel),
		.ext_reset_n_o(ext_reset_n_i), .src_o(gc_src_i), .period_o(period));
	always #50 clk_i = !clk_i;
	task results;
		if (fails == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input [31:0] s, e);
		check_count = check_count + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input [9:0] a, input [31:0] v);
		@(posedge clk_i);
		{avs_address_i, avs_writedata_i, avs_write_i} <= {a, v, 1'b1};
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
	endtask
	task rd(input [9:0] a);
		@(posedge clk_i);
		{avs_address_i, avs_read_i} <= {a, 1'b1};
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		d = avs_readdata_o;
		avs_read_i <= 1'b0;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		fails = fails + 1;
		results();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		{nrst_i, fuse_valid_i} <= 2'b11;
		wr(`PM_RCCR, {`KEY_FIRST, 24'h000000});
		wr(`PM_RCCR, {`KEY_SECOND, 24'h00ABCD});
		wr(`PM_RCCR, {`KEY_SECOND, 24'h001111});
		wr(`PM_RCCR, {`KEY_FIRST, 24'h000000});
		wr(`PM_GPLP0, 32'h5A5A5A5A);
		wr(`PM_RCCR, {`KEY_SECOND, 24'h002222});
		rd(`PM_RCCR);
		chk("rc key", d[23:0], 24'h00ABCD);
		// Rows run back to back so the cause register must drop older bits
		for (i = 0; i < 5; i = i + 1) begin
			{ocd_reset_i, cpu_error_i, wdt_reset_i, pin_low, por_below_i} <= rows[i].src;
			repeat (3) @(posedge clk_i);
			chk("reset outs", {sys_reset_o, wdt_ctrl_reset_o, ocd_reset_o, por_domain_reset_o}, rows[i].outs);
			{ocd_reset_i, cpu_error_i, wdt_reset_i, pin_low, por_below_i} <= 5'h00;
			repeat (4) @(posedge clk_i);
			rd(`PM_RESET_CAUSE_REGISTER);
			chk("cause", d, 32'h1 << rows[i].cause);
			rd(`PM_GPLP0);
			chk("general_low_power_regs", d, rows[i].src[0] ? 32'h0 : 32'h5A5A5A5A);
			rd(`PM_RCCR);
			chk("rc cal", d[23:0], rows[i].src[0] ? fuse_rc_i[23:0] : 24'h00ABCD);
		end
		for (i = 0; i < 16; i = i + 1) begin
			{pba_div_tick_i, pbb_div_tick_i, debug_keep_i, debug_halt_i, pb_run_a_i, pb_run_b_i} <=
				{i[3], i[3], i[2], i[1], i[0], !i[0]};
			@(posedge clk_i);
			@(posedge clk_i);
			chk("pb enables", pb_en, {i[0] & i[3], !i[0] & i[3], i[0], !i[0]} & {4{!(i[1] & !i[2])}});
		end
		{debug_halt_i, pb_run_b_i} <= 2'b01;
		for (i = 0; i < 5; i = i + 1) begin
			sel <= i[2:0];
			w = {16'h0000, 7'h00, i == 4, 4'h1, 2'b01, i[1:0]};
			wr(10'(`PM_GCC0 + 4 * i), w);
			repeat (100) @(posedge clk_i);
			chk("gclk period", period, 8'h04 << (i[1:0] + (i == 4)));
			w[`GC_CEN] = 1'b0;
			wr(10'(`PM_GCC0 + 4 * i), w);
			repeat (40) @(posedge clk_i);
			rd(10'(`PM_GCC0 + 4 * i));
			chk("gclk off", {d[`GC_CEN], generic_clock_o[i]}, 2'b00);
		end
		bod_below_i <= 1'b1;
		rd(`PM_POSCSR);
		chk("bod off", {d[`POSCSR_BODET], sys_reset_o, brownout_irq_o}, 3'h4);
		for (i = 2; i > 0; i = i - 1) begin
			bod_below_i <= 1'b0;
			wr(`PM_BOD, {`KEY_FIRST, 24'h000000});
			wr(`PM_BOD, {`KEY_SECOND, 14'h0000, i[1:0], 8'h03});
			bod_below_i <= 1'b1;
			rd(`PM_POSCSR);
			chk("bod action", {d[`POSCSR_BODET], sys_reset_o, brownout_irq_o}, {1'b1, i == 1, i == 2});
		end
		bod_below_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(`PM_RESET_CAUSE_REGISTER);
		chk("bod cause", d, 32'h1 << `CAUSE_BOD);
		rd(`PM_BOD);
		chk("bod kept", d[9:0], 10'h103);
		jtag_hold_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("jtag", sys_reset_o, 1'b1);
		jtag_hold_i <= 1'b0;
		rd(10'h3FC);
		chk("unmapped", d, 32'h0);
		results();
	end
endmodule // test_power_manager_reset_clock_ctl
